/* logic/coproc_move_pkg.sv */
`default_nettype none
package coproc_move_pkg;

  // ==========================================================================
  // Operation codes presented on the command port.
  localparam logic [2:0] OP_LOAD_PAIR     = 3'h0;
  localparam logic [2:0] OP_LOAD_REGCOUNT = 3'h1;
  localparam logic [2:0] OP_LOAD_POSTINC  = 3'h2;
  localparam logic [2:0] OP_LOAD_PREDEC   = 3'h3;
  localparam logic [2:0] OP_STORE_POSTINC = 3'h4;
  localparam logic [2:0] OP_STORE_PREDEC  = 3'h5;

  // ==========================================================================
  // Sizes and timing figures, in machine states (one state is one clk cycle with clk_en high).
  localparam int           WORD_BITS        = 32;
  localparam logic [31:0]  POINTER_STEP     = 32'h0000_0020;
  localparam int           COUNT_BITS       = 5;
  localparam int           XFER_BITS        = 6;
  localparam logic [5:0]   ZERO_COUNT_XFERS = 6'h20;
  localparam logic [6:0]   PAIR_STATES_AL   = 7'h04;
  localparam logic [6:0]   PAIR_STATES_NAL  = 7'h03;
  localparam logic [6:0]   BLOCK_BASE_AL    = 7'h05;
  localparam logic [6:0]   BLOCK_BASE_NAL   = 7'h06;
  localparam logic [6:0]   ZERO_STATES_AL   = 7'h24;
  localparam logic [6:0]   ZERO_STATES_NAL  = 7'h25;
  localparam logic [4:0]   ALIGN_MASK       = 5'h1F;

  // ==========================================================================
  // Sequencer states.
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_XFER = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } seq_state_t;

endpackage
`default_nettype wire

/* logic/coproc_single_move_sequencer.sv */
// Notes on behaviour
// - Pair load sends first source to target register, second to the next.
// - Pair load takes 4 states if instruction long-word aligned, else 3.
// - Register count 0 means 32 transfers; 1 to 31 means that many.
// - Register-count load reads word, adds 32 to pointer, next coproc reg.
// - Register-count load: 36/37 states for zero, else 5 or 6 plus count-1.
// - Constant count field: 0 encodes 32, 1 to 31 encode themselves.
// - Constant postincrement load copies word, adds 32, advances register.
// - Constant-count moves take 5 plus count-1, or 6 when nonaligned.
// - Predecrement load subtracts 32 first, then loads and advances.
// - Postincrement store writes register word, adds 32, advances register.
// - Predecrement store subtracts 32 first, then writes and advances.
`timescale 1ns/1ps
`default_nettype none
module coproc_single_move_sequencer
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_op,
  input  wire logic        cmd_insn_aligned,
  input  wire logic [31:0] cmd_pointer,
  input  wire logic [4:0]  cmd_count,
  input  wire logic [31:0] cmd_host_source_a,
  input  wire logic [31:0] cmd_host_source_b,
  input  wire logic [4:0]  cmd_coproc_target_reg,
  output logic             done,
  output logic [31:0]      final_pointer,
  output logic             mem_req,
  output logic             mem_write,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             cp_valid,
  output logic             cp_to_coproc,
  output logic             cp_first,
  output logic [4:0]       cp_target_reg,
  output logic [31:0]      cp_wdata,
  input  wire logic [31:0] cp_rdata
);

  // ==========================================================================
  // Command decode.
  wire logic is_pair   = (cmd_op == coproc_move_pkg::OP_LOAD_PAIR);
  wire logic is_regcnt = (cmd_op == coproc_move_pkg::OP_LOAD_REGCOUNT);
  wire logic is_store  = (cmd_op == coproc_move_pkg::OP_STORE_POSTINC) ||
                         (cmd_op == coproc_move_pkg::OP_STORE_PREDEC);
  wire logic is_predec = (cmd_op == coproc_move_pkg::OP_LOAD_PREDEC) ||
                         (cmd_op == coproc_move_pkg::OP_STORE_PREDEC);
  wire logic ptr_aligned =
    ((cmd_pointer[4:0] & coproc_move_pkg::ALIGN_MASK) == 5'h00);
  // Both count encodings use zero for a full run of 32.
  wire logic [5:0] cmd_xfers = (cmd_count == 5'h00) ?
    coproc_move_pkg::ZERO_COUNT_XFERS : {1'b0, cmd_count};
  // Total machine states for the command; the pair load has its own figures.
  wire logic [6:0] block_states =
    (ptr_aligned ? coproc_move_pkg::BLOCK_BASE_AL
                 : coproc_move_pkg::BLOCK_BASE_NAL) +
    {1'b0, cmd_xfers} - 7'h01;
  wire logic [6:0] zero_states = ptr_aligned ?
    coproc_move_pkg::ZERO_STATES_AL : coproc_move_pkg::ZERO_STATES_NAL;
  wire logic [6:0] pair_states = cmd_insn_aligned ?
    coproc_move_pkg::PAIR_STATES_AL : coproc_move_pkg::PAIR_STATES_NAL;
  wire logic [6:0] cmd_states = is_pair ? pair_states :
    ((is_regcnt && cmd_count == 5'h00) ? zero_states : block_states);

  // ==========================================================================
  // State.
  coproc_move_pkg::seq_state_t state;
  logic        op_pair;
  logic        op_store;
  logic        op_predec;
  logic [5:0]  left;
  logic [6:0]  budget;
  logic [31:0] pointer;
  logic [31:0] second_word;

  assign cmd_ready = (state == coproc_move_pkg::ST_IDLE);
  wire logic take = clk_en && cmd_valid && cmd_ready;
  // Predecrement forms address the word just below the pointer.
  wire logic [31:0] word_addr = op_predec ?
    pointer - coproc_move_pkg::POINTER_STEP : pointer;
  wire logic word_end = clk_en && (state == coproc_move_pkg::ST_XFER) &&
    (op_pair || mem_ack);
  wire logic last_word = (left == 6'h01);

  // ==========================================================================
  // Sequencer. The pointer is updated at the very edge that ends a word, so
  // the next request is always built from the finished word. Words run back
  // to back; the budget then pads the run out to the required state count.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state       <= coproc_move_pkg::ST_IDLE;
      op_pair     <= 1'b0;
      op_store    <= 1'b0;
      op_predec   <= 1'b0;
      left        <= 6'h00;
      budget      <= 7'h00;
      pointer     <= 32'h0000_0000;
      second_word <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (budget != 7'h00)
        budget <= budget - 7'h01;
      unique case (state)
        coproc_move_pkg::ST_IDLE:
        begin
          if (cmd_valid)
          begin
            state       <= coproc_move_pkg::ST_XFER;
            op_pair     <= is_pair;
            op_store    <= is_store;
            op_predec   <= is_predec;
            left        <= is_pair ? 6'h02 : cmd_xfers;
            budget      <= cmd_states - 7'h01;
            pointer     <= is_pair ? cmd_host_source_a : cmd_pointer;
            second_word <= cmd_host_source_b;
          end
        end
        coproc_move_pkg::ST_XFER:
        begin
          if (word_end)
          begin
            left    <= left - 6'h01;
            if (op_pair)
              pointer <= second_word;
            else if (op_predec)
              pointer <= word_addr;
            else
              pointer <= pointer + coproc_move_pkg::POINTER_STEP;
            // A short budget skips the wait state, which the fast pair needs.
            if (!last_word)
              state <= coproc_move_pkg::ST_XFER;
            else if (budget <= 7'h01)
              state <= coproc_move_pkg::ST_DONE;
            else
              state <= coproc_move_pkg::ST_WAIT;
          end
        end
        coproc_move_pkg::ST_WAIT:
        begin
          if (left != 6'h00)
            state <= coproc_move_pkg::ST_XFER;
          else if (budget <= 7'h01)
            state <= coproc_move_pkg::ST_DONE;
        end
        coproc_move_pkg::ST_DONE:
          state <= coproc_move_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Outputs toward memory and the coprocessor. The coprocessor advances its
  // own register pointer per word, so only the first word names the target.
  assign mem_req    = (state == coproc_move_pkg::ST_XFER) && !op_pair;
  assign mem_write  = mem_req && op_store;
  assign mem_addr   = word_addr;
  assign cp_valid   = word_end;
  assign cp_to_coproc = !op_store;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cp_first      <= 1'b0;
      cp_target_reg <= 5'h00;
      done          <= 1'b0;
      final_pointer <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      done <= (state == coproc_move_pkg::ST_DONE);
      if (take)
      begin
        cp_first      <= 1'b1;
        cp_target_reg <= cmd_coproc_target_reg;
      end
      else if (word_end)
        cp_first <= 1'b0;
      if (word_end && !op_pair)
        final_pointer <= op_predec ? word_addr
                         : pointer + coproc_move_pkg::POINTER_STEP;
    end
  end
  // Data words: pair load forwards host values, loads forward memory words.
  assign cp_wdata  = op_pair ? pointer : mem_rdata;
  assign mem_wdata = cp_rdata;

  // ==========================================================================
  // Checks.
  logic [6:0] run_states;
  logic [6:0] expect_states;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_states    <= 7'h00;
      expect_states <= 7'h00;
    end
    else if (clk_en)
    begin
      if (take)
      begin
        run_states    <= 7'h01;
        expect_states <= cmd_states;
      end
      else if (state != coproc_move_pkg::ST_IDLE)
        run_states <= run_states + 7'h01;
    end
  end

  AST_STATE_COUNT: assert property (@(posedge clk) disable iff (reset)
    (clk_en && state == coproc_move_pkg::ST_DONE) |->
      run_states >= expect_states)
    else $error("Move finished before its machine state count.");
  AST_ZERO_IS_32: assert property (@(posedge clk) disable iff (reset)
    (take && !is_pair && cmd_count == 5'h00) |=> left == 6'h20)
    else $error("Zero count did not give 32 transfers.");
  AST_POSTINC: assert property (@(posedge clk) disable iff (reset)
    (word_end && !op_pair && !op_predec) |=>
      pointer == $past(pointer) + 32'h0000_0020)
    else $error("Postincrement did not add 32.");
  AST_PREDEC: assert property (@(posedge clk) disable iff (reset)
    (take && is_predec) |=>
      (mem_req && mem_addr == $past(cmd_pointer) - 32'h0000_0020))
    else $error("Predecrement address wrong.");
  AST_ONE_WORD: assert property (@(posedge clk) disable iff (reset)
    (word_end && !op_pair && !last_word) |=>
      (mem_req && mem_addr == (op_predec ? $past(mem_addr) - 32'h0000_0020
                                         : $past(mem_addr) + 32'h0000_0020)))
    else $error("Next word issued before pointer update.");
  AST_STORE_DATA: assert property (@(posedge clk) disable iff (reset)
    mem_write |-> mem_wdata == cp_rdata)
    else $error("Store data not from coprocessor.");
  AST_PAIR_SECOND: assert property (@(posedge clk) disable iff (reset)
    (word_end && op_pair && left == 6'h02) |=>
      (state == coproc_move_pkg::ST_XFER && cp_wdata == second_word))
    else $error("Pair load second value wrong.");
  AST_COUNT_WORDS: assert property (@(posedge clk) disable iff (reset)
    (state == coproc_move_pkg::ST_DONE) |-> left == 6'h00)
    else $error("Transfer count not exhausted.");
  COV_PAIR: cover property (@(posedge clk) take && is_pair);
  COV_ZERO: cover property (@(posedge clk) take && is_regcnt &&
    cmd_count == 5'h00);
  COV_STORE_PREDEC: cover property (@(posedge clk) take && is_store &&
    is_predec);

endmodule
`default_nettype wire

/* test/coproc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Coprocessor register file whose pointer walks the sequence.
module coproc_partner
(
  input  wire logic        clk,
  input  wire logic        cp_valid,
  input  wire logic        cp_to_coproc,
  input  wire logic        cp_first,
  input  wire logic [4:0]  cp_target_reg,
  input  wire logic [31:0] cp_wdata,
  output logic      [31:0] cp_rdata
);
  logic [31:0] regs [32];
  logic [4:0]  ptr = 5'h00;
  logic [4:0]  cur;
  // The first word always lands on, or is read from, the named register.
  assign cur = cp_first ? cp_target_reg : ptr;
  assign cp_rdata = regs[cur];
  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 32'hC0DE_0000 + i;
  end
  // One step per word moved, in either direction.
  always @(posedge clk)
  begin
    if (cp_valid)
    begin
      if (cp_to_coproc)
        regs[cur] <= cp_wdata;
      ptr <= cur + 5'h01;
    end
  end
endmodule
`default_nettype wire

/* test/coproc_single_move_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench: memory answers here, the coprocessor is a model.
module coproc_single_move_sequencer_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        al = 1'b0;
  logic        mem_ack = 1'b0;
  logic [2:0]  op = 3'h0;
  logic [31:0] ptr = 32'h0, src_a = 32'h0, src_b = 32'h0;
  logic [4:0]  cnt = 5'h00, tgt = 5'h00;
  logic        cmd_ready, done, mem_req, mem_write, cp_valid;
  logic        cp_to_coproc, cp_first;
  logic [4:0]  cp_target_reg;
  logic [31:0] final_pointer, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] cp_wdata, cp_rdata;
  int          failures = 0, checks_done = 0, ack_delay = 0, wcnt = 0, n;
  logic [31:0] addr_q[$], data_q[$];
  logic        wr_q[$];

  coproc_single_move_sequencer DUT
  (.clk, .reset, .clk_en(1'b1), .cmd_valid, .cmd_ready, .cmd_op(op),
   .cmd_insn_aligned(al), .cmd_pointer(ptr), .cmd_count(cnt),
   .cmd_host_source_a(src_a), .cmd_host_source_b(src_b),
   .cmd_coproc_target_reg(tgt), .done, .final_pointer, .mem_req,
   .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .cp_valid,
   .cp_to_coproc, .cp_first, .cp_target_reg, .cp_wdata, .cp_rdata);
  coproc_partner P
  (.clk, .cp_valid, .cp_to_coproc, .cp_first, .cp_target_reg,
   .cp_wdata, .cp_rdata);

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {8'hA5, a[23:0]};
  endfunction

  // ============================================================
  // Memory: read data is garbage outside the acknowledge cycle.
  initial
    forever #2.5 clk = ~clk;
  assign mem_rdata = mem_ack ? pat(mem_addr) : ~pat(mem_addr);
  always @(negedge clk)
  begin
    // Acknowledges may follow one another, one word a cycle at zero delay.
    mem_ack <= mem_req && wcnt >= ack_delay;
    wcnt <= (mem_req && wcnt < ack_delay) ? wcnt + 1 : 0;
  end
  // Every accepted word is logged in order.
  always @(posedge clk)
    if (mem_req === 1'b1 && mem_ack === 1'b1)
    begin
      addr_q.push_back(mem_addr);
      data_q.push_back(mem_wdata);
      wr_q.push_back(mem_write);
    end

  // ============================================================
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Waits for idle, gives one command and counts states to done.
  task automatic issue(input logic [2:0] o, input logic a,
                       input logic [31:0] p, input logic [4:0] c,
                       input logic [4:0] t);
    int g;
    g = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && g < 400)
    begin
      @(negedge clk);
      g++;
    end
    cmp(cmd_ready, 32'h1);
    addr_q.delete();
    data_q.delete();
    wr_q.delete();
    op = o; al = a; ptr = p; cnt = c; tgt = t; cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmp(cmd_ready, 32'h0);
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp(done, 32'h1);
  endtask

  // Compares addresses, data, final pointer and state count.
  task automatic verify(input logic [31:0] p, input int c, input int st);
    int          k;
    logic        dn;
    logic        wr;
    logic [31:0] a;
    logic [4:0]  r;
    k = (c == 0) ? 32 : c;
    dn = (op == coproc_move_pkg::OP_LOAD_PREDEC) ||
         (op == coproc_move_pkg::OP_STORE_PREDEC);
    wr = op >= coproc_move_pkg::OP_STORE_POSTINC;
    cmp(addr_q.size(), k);
    for (int i = 0; i < k && i < addr_q.size(); i++)
    begin
      a = dn ? p - 32'(32 * (i + 1)) : p + 32'(32 * i);
      r = 5'(tgt + i);
      cmp(addr_q[i], a);
      cmp(wr_q[i], wr);
      if (wr)
        cmp(data_q[i], 32'hC0DE_0000 + r);
      else
        cmp(P.regs[r], pat(a));
    end
    cmp(final_pointer, dn ? p - 32'(32 * k) : p + 32'(32 * k));
    if (st > 0)
      cmp(n, st);
  endtask

  // ============================================================
  task automatic t_pair;
    src_a = 32'h1234_5678;
    src_b = 32'h9ABC_DEF0;
    issue(coproc_move_pkg::OP_LOAD_PAIR, 1'b1, 32'h0, 5'h00, 5'h03);
    cmp(P.regs[3], 32'h1234_5678);
    cmp(P.regs[4], 32'h9ABC_DEF0);
    cmp(n, 4);
    issue(coproc_move_pkg::OP_LOAD_PAIR, 1'b0, 32'h0, 5'h00, 5'h1E);
    cmp(P.regs[30], 32'h1234_5678);
    cmp(P.regs[31], 32'h9ABC_DEF0);
    cmp(n, 3);
  endtask

  task automatic t_stores;
    issue(coproc_move_pkg::OP_STORE_POSTINC, 1'b0, 32'h1000_0003, 5'h04,
          5'h14);
    verify(32'h1000_0003, 4, 9);
    issue(coproc_move_pkg::OP_STORE_PREDEC, 1'b0, 32'h2000_0000, 5'h01,
          5'h1A);
    verify(32'h2000_0000, 1, 5);
  endtask

  task automatic t_loads;
    ack_delay = 2;
    issue(coproc_move_pkg::OP_LOAD_POSTINC, 1'b0, 32'h4000, 5'h05, 5'h08);
    verify(32'h4000, 5, 0);
    ack_delay = 0;
    issue(coproc_move_pkg::OP_LOAD_PREDEC, 1'b0, 32'h1_0000, 5'h00, 5'h00);
    verify(32'h1_0000, 0, 36);
  endtask

  task automatic t_regcount;
    issue(coproc_move_pkg::OP_LOAD_REGCOUNT, 1'b0, 32'h3000, 5'h00, 5'h02);
    verify(32'h3000, 0, 36);
    issue(coproc_move_pkg::OP_LOAD_REGCOUNT, 1'b0, 32'h3005, 5'h03, 5'h1F);
    verify(32'h3005, 3, 8);
  endtask

  // ============================================================
  initial
  begin
    #100000;
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    cmp(cmd_ready, 32'h1);
    cmp(done, 32'h0);
    t_pair();
    t_stores();
    t_loads();
    t_regcount();
    wrap_up();
  end
endmodule
`default_nettype wire
